// *** src/dls_pkg.sv ***
// Shared constants, types and helpers of the logic/stack/repeat unit
// Assumes a 36-bit accumulator datapath and a 16-bit data word
package dls_pkg;

  // Instruction classes accepted by the execution unit
  typedef enum logic [2:0] {
    OP_NOP  = 3'h0,
    OP_OR   = 3'h1,
    OP_PACR = 3'h2,
    OP_POP  = 3'h3,
    OP_PUSH = 3'h4,
    OP_REP  = 3'h5
  } dls_op_e;

  // Source of an OR
  typedef enum logic [1:0] {
    ORS_WORD = 2'h0,
    ORS_ACC  = 2'h1,
    ORS_PROD = 2'h2
  } dls_orsrc_e;

  // Destination of a pop
  typedef enum logic [1:0] {
    POP_GEN  = 2'h0,
    POP_FLAG = 2'h1,
    POP_ST0  = 2'h2,
    POP_PROD = 2'h3
  } dls_popd_e;

  // Repeat sequencer states, Gray along idle-armed-run-tail
  typedef enum logic [1:0] {
    RS_IDLE  = 2'b00,
    RS_ARMED = 2'b01,
    RS_RUN   = 2'b11,
    RS_TAIL  = 2'b10
  } dls_rs_e;

  // Product shift field encodings
  localparam logic [1:0]  PS_NONE   = 2'h0;
  localparam logic [1:0]  PS_R1     = 2'h1;
  localparam logic [1:0]  PS_L1     = 2'h2;
  localparam logic [1:0]  PS_L2     = 2'h3;
  localparam logic [35:0] RND_CONST = 36'h000008000;
  // Flag positions inside status word zero
  localparam int FLG_Z = 15;
  localparam int FLG_M = 14;
  localparam int FLG_N = 13;
  localparam int FLG_V = 12;
  localparam int FLG_C = 11;
  localparam int FLG_E = 10;
  localparam int FLG_L = 9;
  localparam int FLG_R = 8;
  localparam int REP_IMM_W = 8;
  // Reset values
  localparam logic [35:0] ACC_RST  = 36'h000000000;
  localparam logic [31:0] PROD_RST = 32'h00000000;
  localparam logic [15:0] SP_RST   = 16'h0000;
  localparam logic [15:0] ST0_RST  = 16'h0000;
  localparam logic [15:0] LC_RST   = 16'h0000;

  // Sign-extend the product to 36 bits, then shift per field
  function automatic logic [35:0] shifted_p(input logic [31:0] p, input logic [1:0] ps);
    logic [35:0] ext;
    ext = {{4{p[31]}}, p};
    case (ps)
      PS_R1:   shifted_p = {ext[35], ext[35:1]};
      PS_L1:   shifted_p = {ext[34:0], 1'b0};
      PS_L2:   shifted_p = {ext[33:0], 2'b00};
      default: shifted_p = ext;
    endcase
  endfunction : shifted_p

  // Zero, minus, normalized, extension from a 36-bit result
  function automatic logic [3:0] flags_of(input logic [35:0] r);
    logic e;
    e = !((&r[35:31]) || !(|r[35:31]));
    flags_of = {(r == ACC_RST), r[35], !e && (r[31] ^ r[30]), e};
  endfunction : flags_of

endpackage : dls_pkg

// *** src/dls_rep_if.sv ***
// Link between the execution unit and its repeat sequencer
// Assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface dls_rep_if;
  logic        start;
  logic        imm;
  logic        exec;
  logic        irq_req;
  logic        irq_ret;
  logic [15:0] count;
  logic [15:0] lc;
  logic        hold;
  logic        irq_ack;
  modport core (output start, imm, exec, irq_req, irq_ret, count, input lc, hold, irq_ack);
  modport ctl  (input start, imm, exec, irq_req, irq_ret, count, output lc, hold, irq_ack);
endinterface : dls_rep_if
`default_nettype wire

// *** src/dls_rep_ctl.sv ***
// Single-instruction repeat sequencer with one level of nesting
// Assumes exec pulses once per accepted instruction after the repeat
`timescale 1ns/1ps
`default_nettype none
module dls_rep_ctl (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  dls_rep_if.ctl    rif
);
  import dls_pkg::*;

  typedef struct packed {
    dls_rs_e     st;
    logic [15:0] repc;
    logic [15:0] saved;
    logic        saved_v;
    logic        nested;
    logic [15:0] lc;
    logic        hold;
    logic        irq_ack;
  } dls_rep_s;

  dls_rep_s s_r;
  dls_rep_s s_nxt;
  logic     ok;
  logic [15:0] cnt;

  // Immediate counts are zero-extended into the loop count
  assign cnt = rif.imm ? {{(16 - REP_IMM_W){1'b0}}, rif.count[REP_IMM_W-1:0]} : rif.count; // [RULE20]

  // Sequencer; repc is private so block-repeat state is never touched
  always_comb begin // [RULE19]
    s_nxt = s_r;
    ok    = 1'b0;
    case (s_r.st)
      RS_IDLE: begin
        // Held off while an interrupted loop waits, so saved is not lost
        ok = !rif.start && !s_r.saved_v;
        if (rif.start) begin
          s_nxt.st     = RS_ARMED;
          s_nxt.repc   = cnt; // [RULE16]
          s_nxt.lc     = cnt; // [RULE20]
          s_nxt.nested = s_r.saved_v; // [RULE17]
          s_nxt.hold   = 1'b1;
        end else if (rif.irq_ret && s_r.saved_v) begin
          s_nxt.st      = RS_RUN;
          s_nxt.repc    = s_r.saved;
          s_nxt.saved_v = 1'b0;
          s_nxt.hold    = 1'b1;
        end
      end
      RS_ARMED, RS_RUN: begin
        // No interrupt before the first pass or on a nested loop
        ok = (s_r.st == RS_RUN) && !s_r.nested && !rif.exec; // [RULE17] [RULE18]
        if (rif.exec) begin
          if (s_r.repc == 16'h0000) begin
            s_nxt.st     = RS_TAIL;
            s_nxt.hold   = 1'b0;
            s_nxt.nested = 1'b0;
          end else begin
            s_nxt.st   = RS_RUN;
            s_nxt.repc = s_r.repc - 16'h0001; // [RULE16]
          end
        end else if (ok && rif.irq_req) begin // Only an accepted request parks the loop
          s_nxt.saved   = s_r.repc;
          s_nxt.saved_v = 1'b1;
          s_nxt.st      = RS_IDLE;
          s_nxt.hold    = 1'b0;
        end
      end
      RS_TAIL: begin
        // A repeat fetched right after a loop must not be lost; still no interrupt here
        s_nxt.st = RS_IDLE; // [RULE18]
        if (rif.start) begin
          s_nxt.st     = RS_ARMED;
          s_nxt.repc   = cnt; // [RULE16]
          s_nxt.lc     = cnt; // [RULE20]
          s_nxt.nested = s_r.saved_v; // [RULE17]
          s_nxt.hold   = 1'b1;
        end
      end
      default: s_nxt.st = RS_IDLE;
    endcase
    s_nxt.irq_ack = ok && rif.irq_req;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '{st: RS_IDLE, repc: LC_RST, saved: LC_RST, saved_v: 1'b0, nested: 1'b0,
               lc: LC_RST, hold: 1'b0, irq_ack: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rif.lc      = s_r.lc;
  assign rif.hold    = s_r.hold;
  assign rif.irq_ack = s_r.irq_ack;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_rep_single: assert property ( // [RULE16]
    s_r.st == RS_ARMED && s_r.repc == 16'h0000 && rif.exec
    |=> s_r.st == RS_TAIL ##1 s_r.st == ($past(rif.start) ? RS_ARMED : RS_IDLE))
    else $error("zero-count repeat did not end after one pass");
  chk_rep_step: assert property ( // [RULE16]
    s_r.st == RS_RUN && rif.exec && s_r.repc != 16'h0000 |=> s_r.repc == $past(s_r.repc) - 16'h0001)
    else $error("repeat counter did not step");
  chk_rep_nested: assert property ( // [RULE17]
    s_r.nested |=> !s_r.irq_ack)
    else $error("nested repeat was interrupted");
  chk_rep_window: assert property ( // [RULE18]
    s_r.st == RS_ARMED || s_r.st == RS_TAIL |=> !s_r.irq_ack)
    else $error("interrupt taken at a repeat boundary");
  chk_rep_keep: assert property ( // [RULE17] [RULE18]
    (s_r.st == RS_ARMED || (s_r.st == RS_RUN && s_r.nested)) && !rif.exec |=> s_r.hold)
    else $error("protected repeat loop was dropped");
  chk_lc_stable: assert property ( // [RULE19]
    !rif.start |=> $stable(s_r.lc))
    else $error("loop count changed without a repeat start");
  chk_lc_imm: assert property ( // [RULE20]
    rif.start && rif.imm |=> s_r.lc[15:8] == 8'h00 && s_r.lc[7:0] == $past(rif.count[7:0]))
    else $error("immediate count not zero-extended");

  cov_rep_irq: cover property (s_r.st == RS_RUN && rif.irq_req && !rif.exec ##1 s_r.irq_ack);
  cov_rep_nest: cover property (s_r.saved_v && rif.start ##1 s_r.nested);
  cov_rep_resume: cover property (s_r.saved_v && rif.irq_ret ##1 s_r.st == RS_RUN);
endmodule : dls_rep_ctl
`default_nettype wire

// *** src/dls_exec_top.sv ***
// Execution unit: OR, product round, stack push/pop and repeat issue
// Assumes decoded operands and a stack RAM read combinationally at SP_O
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE1] Wide OR sources use all 36 bits
// [RULE2] Word OR zero-extends, upper bits kept
// [RULE3] OR takes two cycles when two-word
// [RULE4] OR sets Z M N E only
// [RULE5] Round loads shifted product plus constant
// [RULE6] Product sign-extended then shifted by field
// [RULE7] Pop reads at pointer, then increments
// [RULE8] Pop to flag register sets Z M N E
// [RULE9] Pop to status zero loads whole word
// [RULE10] Pop to product loads high half only
// [RULE11] Software never pops to pointer or secondary
// [RULE12] Push decrements pointer, then writes word
// [RULE13] Push from accumulator half sets limit only
// [RULE14] Push long immediate takes two cycles
// [RULE15] Software avoids illegal push sources and order
// [RULE16] Repeat runs next instruction count plus one
// [RULE17] Outer repeat interruptible, nested one not
// [RULE18] No interrupt at repeat entry or exit
// [RULE19] Repeat leaves block-repeat state alone
// [RULE20] Immediate count zero-extended into loop count
module dls_exec_top (
  input  wire logic                MCLK_I,
  input  wire logic                RSTN_I,
  input  wire logic                INSTR_VALID_I,
  input  wire dls_pkg::dls_op_e    OP_I,
  input  wire logic                TWO_WORD_I,
  input  wire logic                DST_I,
  input  wire dls_pkg::dls_orsrc_e OR_SRC_I,
  input  wire logic                SRC_ACC_I,
  input  wire logic [15:0]         OPERAND_I,
  input  wire logic [1:0]          PS_I,
  input  wire dls_pkg::dls_popd_e  POP_DST_I,
  input  wire logic                PUSH_HALF_I,
  input  wire logic                PUSH_LIMIT_I,
  input  wire logic                REP_IMM_I,
  input  wire logic [15:0]         MEM_RDATA_I,
  input  wire logic                IRQ_REQ_I,
  input  wire logic                IRQ_RET_I,
  output logic [35:0]              ACC0_O,
  output logic [35:0]              ACC1_O,
  output logic [31:0]              PROD_O,
  output logic [15:0]              SP_O,
  output logic [15:0]              ST0_O,
  output logic                     MEM_WE_O,
  output logic [15:0]              MEM_WDATA_O,
  output logic                     POP_WE_O,
  output logic [15:0]              POP_DATA_O,
  output logic                     BUSY_O,
  output logic [15:0]              LC_O,
  output logic                     REP_HOLD_O,
  output logic                     IRQ_ACK_O
);
  import dls_pkg::*;

  typedef struct packed {
    logic [35:0] acc0;
    logic [35:0] acc1;
    logic [31:0] prod;
    logic [15:0] sp;
    logic [15:0] st0;
    logic        mem_we;
    logic [15:0] mem_wdata;
    logic        pop_we;
    logic [15:0] pop_data;
    logic        busy;
  } dls_core_s;

  dls_core_s   s_r;
  dls_core_s   s_nxt;
  logic        take;
  logic [35:0] acc_dst;
  logic [35:0] or_src;
  logic [35:0] res;
  logic [3:0]  fl;

  dls_rep_if rif ();

  // Second word of a two-word instruction blocks issue for one cycle
  assign take    = INSTR_VALID_I && !s_r.busy;
  assign acc_dst = DST_I ? s_r.acc1 : s_r.acc0;
  // Word operands are zero-extended, so the OR keeps bits 35:16
  assign or_src  = (OR_SRC_I == ORS_PROD) ? shifted_p(s_r.prod, PS_I) :   // [RULE1] [RULE6]
                   (OR_SRC_I == ORS_ACC)  ? (SRC_ACC_I ? s_r.acc1 : s_r.acc0) : // [RULE1]
                   {20'h00000, OPERAND_I};                               // [RULE2]

  // Repeat sequencer requests
  assign rif.start   = take && (OP_I == OP_REP);
  assign rif.exec    = take && (OP_I != OP_REP);
  assign rif.imm     = REP_IMM_I;
  assign rif.count   = OPERAND_I;
  assign rif.irq_req = IRQ_REQ_I;
  assign rif.irq_ret = IRQ_RET_I;

  dls_rep_ctl u_rep (
    .clk_i   (MCLK_I),
    .rst_n_i (RSTN_I),
    .rif     (rif)
  );

  // Datapath; one instruction per accepted cycle
  always_comb begin
    s_nxt        = s_r;
    s_nxt.mem_we = 1'b0;
    s_nxt.pop_we = 1'b0;
    s_nxt.busy   = 1'b0;
    res          = ACC_RST;
    fl           = 4'h0;
    if (take) begin
      case (OP_I)
        OP_OR: begin
          res        = acc_dst | or_src; // [RULE1] [RULE2]
          fl         = flags_of(res);
          s_nxt.busy = TWO_WORD_I; // [RULE3]
          if (DST_I) begin
            s_nxt.acc1 = res;
          end else begin
            s_nxt.acc0 = res;
          end
          // V, C, L and R are left as they were
          s_nxt.st0[FLG_Z] = fl[3]; // [RULE4]
          s_nxt.st0[FLG_M] = fl[2]; // [RULE4]
          s_nxt.st0[FLG_N] = fl[1]; // [RULE4]
          s_nxt.st0[FLG_E] = fl[0]; // [RULE4]
        end
        OP_PACR: begin
          res = shifted_p(s_r.prod, PS_I) + RND_CONST; // [RULE5] [RULE6]
          if (DST_I) begin
            s_nxt.acc1 = res;
          end else begin
            s_nxt.acc0 = res;
          end
        end
        OP_POP: begin
          // Pointer or secondary targets are not decoded here
          s_nxt.sp = s_r.sp + 16'h0001; // [RULE7] [RULE11]
          case (POP_DST_I)
            POP_FLAG: begin
              s_nxt.st0[FLG_Z] = MEM_RDATA_I[FLG_Z]; // [RULE8]
              s_nxt.st0[FLG_M] = MEM_RDATA_I[FLG_M]; // [RULE8]
              s_nxt.st0[FLG_N] = MEM_RDATA_I[FLG_N]; // [RULE8]
              s_nxt.st0[FLG_E] = MEM_RDATA_I[FLG_E]; // [RULE8]
            end
            POP_ST0:  s_nxt.st0 = MEM_RDATA_I; // [RULE9]
            POP_PROD: s_nxt.prod[31:16] = MEM_RDATA_I; // [RULE10]
            default: begin
              s_nxt.pop_we   = 1'b1; // [RULE7]
              s_nxt.pop_data = MEM_RDATA_I;
            end
          endcase
        end
        OP_PUSH: begin
          // Write lands one cycle later at the new pointer
          s_nxt.sp        = s_r.sp - 16'h0001; // [RULE12]
          s_nxt.mem_we    = 1'b1; // [RULE12]
          s_nxt.mem_wdata = OPERAND_I;
          s_nxt.busy      = TWO_WORD_I; // [RULE14]
          if (PUSH_HALF_I) begin
            s_nxt.st0[FLG_L] = PUSH_LIMIT_I; // [RULE13]
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s_r <= '{acc0: ACC_RST, acc1: ACC_RST, prod: PROD_RST, sp: SP_RST, st0: ST0_RST,
               mem_we: 1'b0, mem_wdata: 16'h0000, pop_we: 1'b0, pop_data: 16'h0000,
               busy: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs are the state flops themselves
  assign ACC0_O      = s_r.acc0;
  assign ACC1_O      = s_r.acc1;
  assign PROD_O      = s_r.prod;
  assign SP_O        = s_r.sp;
  assign ST0_O       = s_r.st0;
  assign MEM_WE_O    = s_r.mem_we;
  assign MEM_WDATA_O = s_r.mem_wdata;
  assign POP_WE_O    = s_r.pop_we;
  assign POP_DATA_O  = s_r.pop_data;
  assign BUSY_O      = s_r.busy;
  assign LC_O        = rif.lc;
  assign REP_HOLD_O  = rif.hold;
  assign IRQ_ACK_O   = rif.irq_ack;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);

  chk_or_wide: assert property ( // [RULE1]
    take && OP_I == OP_OR && OR_SRC_I == ORS_ACC && !DST_I
    |=> ACC0_O == ($past(ACC0_O) | $past(or_src)))
    else $error("wide OR result wrong");
  chk_or_low: assert property ( // [RULE2]
    take && OP_I == OP_OR && OR_SRC_I == ORS_WORD && !DST_I
    |=> ACC0_O[35:16] == $past(ACC0_O[35:16])
        && ACC0_O[15:0] == ($past(ACC0_O[15:0]) | $past(OPERAND_I)))
    else $error("word OR touched upper bits");
  chk_two_word: assert property ( // [RULE3] [RULE14]
    take && (OP_I == OP_OR || OP_I == OP_PUSH) && TWO_WORD_I |=> BUSY_O ##1 !BUSY_O)
    else $error("two-word instruction did not stall one cycle");
  chk_or_flags: assert property ( // [RULE4]
    take && OP_I == OP_OR |=> ST0_O[FLG_V] == $past(ST0_O[FLG_V])
        && ST0_O[FLG_C] == $past(ST0_O[FLG_C]) && ST0_O[FLG_L] == $past(ST0_O[FLG_L])
        && ST0_O[FLG_Z] == (($past(DST_I) ? ACC1_O : ACC0_O) == ACC_RST))
    else $error("OR flag update wrong");
  chk_pacr_val: assert property ( // [RULE5] [RULE6]
    take && OP_I == OP_PACR && !DST_I && PS_I == PS_NONE
    |=> ACC0_O == {{4{$past(PROD_O[31])}}, $past(PROD_O)} + RND_CONST)
    else $error("product round result wrong");
  chk_pop_sp: assert property ( // [RULE7]
    take && OP_I == OP_POP && POP_DST_I == POP_GEN
    |=> SP_O == $past(SP_O) + 16'h0001 && POP_WE_O && POP_DATA_O == $past(MEM_RDATA_I))
    else $error("pop pointer or data wrong");
  chk_pop_flag: assert property ( // [RULE8]
    take && OP_I == OP_POP && POP_DST_I == POP_FLAG
    |=> ST0_O[FLG_C] == $past(ST0_O[FLG_C]) && ST0_O[FLG_Z] == $past(MEM_RDATA_I[FLG_Z]))
    else $error("pop to flag register wrong");
  chk_pop_st0: assert property ( // [RULE9]
    take && OP_I == OP_POP && POP_DST_I == POP_ST0 |=> ST0_O == $past(MEM_RDATA_I))
    else $error("pop to status word wrong");
  chk_pop_prod: assert property ( // [RULE10]
    take && OP_I == OP_POP && POP_DST_I == POP_PROD
    |=> PROD_O == {$past(MEM_RDATA_I), $past(PROD_O[15:0])})
    else $error("pop to product wrong");
  chk_push_wr: assert property ( // [RULE12]
    take && OP_I == OP_PUSH
    |=> MEM_WE_O && SP_O == $past(SP_O) - 16'h0001 && MEM_WDATA_O == $past(OPERAND_I))
    else $error("push write wrong");
  chk_push_flag: assert property ( // [RULE13]
    take && OP_I == OP_PUSH && !PUSH_HALF_I |=> $stable(ST0_O))
    else $error("push changed flags");

  cov_or_two: cover property (take && OP_I == OP_OR && TWO_WORD_I);
  cov_push_pop: cover property (take && OP_I == OP_PUSH ##2 take && OP_I == OP_POP);
endmodule : dls_exec_top
`default_nettype wire

// *** dv/dsp_logic_stack_repeat_ops_test.sv ***
// Self-checking bench for the OR, round, push/pop and repeat execution unit
// Assumes the unit package is compiled first; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none
module dsp_logic_stack_repeat_ops_test;
  import dls_pkg::*;

  // Stimulus, all moved by non-blocking assignment on the rising edge
  logic        mclk        = 1'b0;
  logic        rstn        = 1'b0;
  logic        instr_valid = 1'b0;
  dls_op_e     op          = OP_NOP;
  logic        two_word    = 1'b0;
  logic        dst         = 1'b0;
  dls_orsrc_e  or_src      = ORS_WORD;
  logic        src_acc     = 1'b0;
  logic [15:0] operand     = 16'h0000;
  logic [1:0]  ps          = PS_NONE;
  dls_popd_e   pop_dst     = POP_GEN;
  logic        push_half   = 1'b0;
  logic        push_limit  = 1'b0;
  logic        rep_imm     = 1'b0;
  logic [15:0] mem_rdata   = 16'h0000;
  logic        irq_req     = 1'b0;
  logic        irq_ret     = 1'b0;
  // Observed outputs
  logic [35:0] acc0, acc1;
  logic [31:0] prod;
  logic [15:0] sp, st0, mem_wdata, pop_data, lc;
  logic        mem_we, pop_we, busy, rep_hold, irq_ack;
  int          miscompares  = 0;
  int          total_checks = 0;

  always #2.5 mclk = ~mclk;

  dls_exec_top uut (
    .MCLK_I(mclk), .RSTN_I(rstn), .INSTR_VALID_I(instr_valid), .OP_I(op),
    .TWO_WORD_I(two_word), .DST_I(dst), .OR_SRC_I(or_src), .SRC_ACC_I(src_acc),
    .OPERAND_I(operand), .PS_I(ps), .POP_DST_I(pop_dst), .PUSH_HALF_I(push_half),
    .PUSH_LIMIT_I(push_limit), .REP_IMM_I(rep_imm), .MEM_RDATA_I(mem_rdata),
    .IRQ_REQ_I(irq_req), .IRQ_RET_I(irq_ret), .ACC0_O(acc0), .ACC1_O(acc1),
    .PROD_O(prod), .SP_O(sp), .ST0_O(st0), .MEM_WE_O(mem_we), .MEM_WDATA_O(mem_wdata),
    .POP_WE_O(pop_we), .POP_DATA_O(pop_data), .BUSY_O(busy), .LC_O(lc),
    .REP_HOLD_O(rep_hold), .IRQ_ACK_O(irq_ack)
  );

  // Case inequality so an unknown never passes
  task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // One instruction for one edge; fl = {two, dst, sacc, half, limit, rimm}
  // Stack read data mirrors the operand, as a combinational RAM would show it
  task automatic issue(input dls_op_e o, input logic [15:0] d, input logic [1:0] sel,
                       input logic [1:0] ps_v, input logic [5:0] fl, input logic irq);
    @(posedge mclk);
    instr_valid <= 1'b1;
    op          <= o;
    operand     <= d;
    mem_rdata   <= d;
    or_src      <= dls_orsrc_e'(sel);
    pop_dst     <= dls_popd_e'(sel);
    ps          <= ps_v;
    {two_word, dst, src_acc, push_half, push_limit, rep_imm} <= fl;
    @(posedge mclk);
    instr_valid <= 1'b0;
    irq_req     <= irq;
    @(negedge mclk);
  endtask : issue

  // Back-to-back executions under a repeat; acks must stay away throughout
  task automatic run_execs(input int n, input logic hold_after);
    @(posedge mclk);
    instr_valid <= 1'b1;
    op          <= OP_NOP;
    repeat (n) begin
      @(negedge mclk);
      check(rep_hold, 1'b1, "hold in loop");
      check(irq_ack, 1'b0, "ack in loop");
      @(posedge mclk);
    end
    instr_valid <= 1'b0;
    @(negedge mclk);
    check(rep_hold, hold_after, "hold after");
  endtask : run_execs

  task automatic t_reset();
    check(acc0, 36'h000000000, "acc0 rst");
    check(sp, 16'h0000, "sp rst");
    check(st0, 16'h0000, "st0 rst");
    check(lc, 16'h0000, "lc rst");
    check({rep_hold, mem_we, busy}, 3'h0, "strobes rst");
    $display("test reset done");
  endtask : t_reset

  // Legal destinations only: never the pointer or a secondary accumulator
  task automatic t_pops();
    issue(OP_POP, 16'h1B00, 2'h2, PS_NONE, 6'h00, 1'b0);
    check(st0, 16'h1B00, "pop st0");
    check(sp, 16'h0001, "pop sp");
    issue(OP_POP, 16'hC001, 2'h3, PS_NONE, 6'h00, 1'b0);
    check(prod, 32'hC0010000, "pop prod");
    issue(OP_POP, 16'h1234, 2'h0, PS_NONE, 6'h00, 1'b0);
    check({pop_we, pop_data}, 17'h11234, "pop gen");
    issue(OP_POP, 16'hA500, 2'h1, PS_NONE, 6'h00, 1'b0);
    check(st0, 16'hBF00, "pop flags");
    check(sp, 16'h0004, "pop sp end");
    $display("test pops done");
  endtask : t_pops

  // Every shift code, into the second accumulator; flags left alone
  task automatic t_round();
    logic [1:0]  pss [4]   = '{PS_R1, PS_L2, PS_NONE, PS_L1};
    logic [35:0] exp_r [4] = '{36'hFE0010000, 36'hF00048000, 36'hFC0018000, 36'hF80028000};
    for (int i = 0; i < 4; i++) begin
      issue(OP_PACR, 16'h0000, 2'h0, pss[i], 6'h10, 1'b0);
      check(acc1, exp_r[i], "round acc1");
    end
    issue(OP_PACR, 16'h0000, 2'h0, PS_NONE, 6'h00, 1'b0);
    check(acc0, 36'hFC0018000, "round acc0");
    check(st0, 16'hBF00, "round flags");
    $display("test round done");
  endtask : t_round

  // Two-word OR with a second OR offered in its dead cycle, then wide sources
  task automatic t_or();
    @(posedge mclk);
    instr_valid <= 1'b1;
    op          <= OP_OR;
    or_src      <= ORS_WORD;
    two_word    <= 1'b1;
    dst         <= 1'b0;
    operand     <= 16'h0F0F;
    @(posedge mclk);
    two_word    <= 1'b0;
    operand     <= 16'hFFFF;
    @(negedge mclk);
    check(busy, 1'b1, "or busy");
    check(acc0, 36'hFC0018F0F, "or word");
    check(st0, 16'h5B00, "or flags");
    @(posedge mclk);
    instr_valid <= 1'b0;
    @(negedge mclk);
    check(busy, 1'b0, "busy end");
    check(acc0, 36'hFC0018F0F, "refused or");
    issue(OP_OR, 16'h0000, 2'h1, PS_NONE, 6'h10, 1'b0);
    check(acc1, 36'hFC0038F0F, "or acc");
    issue(OP_OR, 16'h0000, 2'h2, PS_R1, 6'h00, 1'b0);
    check(acc0, 36'hFE0018F0F, "or prod");
    issue(OP_OR, 16'h0000, 2'h1, PS_NONE, 6'h08, 1'b0);
    check(acc0, 36'hFE0038F0F, "or acc1 src");
    check(st0, 16'h5B00, "or flags wide");
    $display("test or done");
  endtask : t_or

  // Only accumulator halves and immediates pushed, never after a pointer write
  task automatic t_push();
    issue(OP_PUSH, 16'hA5A5, 2'h0, PS_NONE, 6'h04, 1'b0);
    check({mem_we, mem_wdata, sp}, 33'h1A5A50003, "push half");
    check(st0, 16'h5900, "push limit");
    issue(OP_PUSH, 16'h3C3C, 2'h0, PS_NONE, 6'h22, 1'b0);
    check({mem_we, mem_wdata, sp}, 33'h13C3C0002, "push long");
    check(busy, 1'b1, "push busy");
    check(st0, 16'h5900, "push flags");
    $display("test push done");
  endtask : t_push

  // Immediate count, request pending from entry to exit
  task automatic t_rep_imm();
    int n;
    issue(OP_REP, 16'h1203, 2'h0, PS_NONE, 6'h01, 1'b1);
    check(lc, 16'h0003, "lc imm");
    run_execs(4, 1'b0);
    @(negedge mclk);
    check(irq_ack, 1'b0, "ack at exit");
    n = 0;
    while (irq_ack !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    check(irq_ack, 1'b1, "idle ack");
    if (irq_ack !== 1'b1) begin
      report_and_stop();
    end
    @(posedge mclk);
    irq_req <= 1'b0;
    $display("test repeat imm done");
  endtask : t_rep_imm

  // Interrupted loop, nested repeat in the handler, resume with the remainder
  task automatic t_rep_irq();
    issue(OP_REP, 16'h0105, 2'h0, PS_NONE, 6'h00, 1'b0);
    check(lc, 16'h0105, "lc reg");
    run_execs(1, 1'b1);
    @(posedge mclk);
    irq_req <= 1'b1;
    @(negedge mclk);
    check(irq_ack, 1'b0, "ack early");
    @(negedge mclk);
    check({irq_ack, rep_hold}, 2'h2, "loop ack");
    issue(OP_REP, 16'h0001, 2'h0, PS_NONE, 6'h01, 1'b1);
    run_execs(2, 1'b0);
    @(negedge mclk);
    check(irq_ack, 1'b0, "saved no ack");
    @(posedge mclk);
    irq_req <= 1'b0;
    irq_ret <= 1'b1;
    @(posedge mclk);
    irq_ret <= 1'b0;
    @(negedge mclk);
    check(rep_hold, 1'b1, "resume");
    // 0x105 + 1 passes in all, one of them before the interrupt
    run_execs(261, 1'b0);
    $display("test repeat irq done");
  endtask : t_rep_irq

  // Reset held six edges, then the scenarios in order
  initial begin
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    t_reset();
    @(posedge mclk);
    rstn <= 1'b1;
    t_pops();
    t_round();
    t_or();
    t_push();
    t_rep_imm();
    t_rep_irq();
    report_and_stop();
  end
endmodule : dsp_logic_stack_repeat_ops_test
`default_nettype wire
